// file: logic/sdram_mode_pkg.sv
// constants for the mode-register and burst sequencing block
// assumes a single rising-edge clock shared with the memory controller
package sdram_mode_pkg;
    // command encodings on {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_BURST_STOP = 4'h6;
    // operating_mode_config field layout
    localparam int BL_LSB = 0;
    localparam int BT_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int OPM_LSB = 7;
    localparam int WBM_BIT = 9;
    localparam int MODE_W = 13;
    // field encodings
    localparam logic [2:0] BL_ONE = 3'h0;
    localparam logic [2:0] BL_TWO = 3'h1;
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] LAT_TWO = 3'h2;
    localparam logic [2:0] LAT_THREE = 3'h3;
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    // bank address that selects the extended register
    localparam logic [1:0] BA_EXT = 2'h2;
    // reset values
    localparam logic [MODE_W-1:0] MODE_RST = 13'h0_020;
    // extended defaults: refresh all 4 banks, full drive, sensor (85C setting)
    localparam logic [MODE_W-1:0] EXT_RST = 13'h0_018;
endpackage : sdram_mode_pkg

// file: logic/sdram_mode_burst.sv
// mode registers, burst column sequencing and read data timing of the sdram
// assumes command pins are already synchronous to clk_sys_in, as in the device
// Functional notes
// - mode bits: 0-2 length, 3 type, 4-6 latency, 7-8 op mode, 9 write mode
// - mode registers hold contents until reloaded
// - load with bank address 10 writes extended register
// - extended register defaults: sensor on, full drive, full-array refresh
// - lengths 1,2,4,8 for both types; full page only sequential
// - burst terminate command stops a running burst
// - burst wraps inside aligned block sized by burst length
// - full page increments through page, wraps to zero, runs until stopped
// - sequential order: next column modulo burst length
// - interleaved order: start offset xor access index
// - read latency two or three clocks; data valid at edge n+m
// - outputs start driving at edge n+m-1
// - op mode bits both zero means normal operation
// - single-write bit forces writes to one location
`timescale 1ns/1ps
module sdram_mode_burst
    import sdram_mode_pkg::*;
#(
    parameter int COL_W = 9
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // command and address pins
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic [1:0] bank_addr_in,
    input wire logic [MODE_W-1:0] addr_in,
    // column sequencing
    output logic [COL_W-1:0] column_out,
    output logic access_read_out,
    output logic access_write_out,
    // read data timing
    output logic dq_drive_out,
    output logic dq_valid_out,
    // stored configuration
    output logic [MODE_W-1:0] operating_mode_config_out,
    output logic [MODE_W-1:0] extended_mode_config_out,
    output logic normal_mode_out
);
    if (COL_W < 3 || COL_W > MODE_W) begin : g_bad_col_w
        $error("COL_W out of range");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } burst_state_e;

    logic [MODE_W-1:0] mode_r;
    logic [MODE_W-1:0] ext_r;
    burst_state_e state_r, state_nxt;
    logic [COL_W-1:0] base_r;
    logic [COL_W-1:0] col_r;
    logic [2:0] start_r;
    logic [COL_W-1:0] idx_r;
    logic [COL_W-1:0] left_r;
    logic interleave_r;
    logic [2:0] wrap_bits_r;
    logic page_r;
    logic [1:0] rd_pipe_r;

    wire [3:0] cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
    wire load_cmd = (cmd == CMD_LOAD_MODE);
    wire load_main = load_cmd && (bank_addr_in == 2'h0);
    wire load_ext = load_cmd && (bank_addr_in == BA_EXT);
    wire rd_cmd = (cmd == CMD_READ);
    wire wr_cmd = (cmd == CMD_WRITE);
    wire stop_cmd = (cmd == CMD_BURST_STOP);
    wire [2:0] bl_code = mode_r[BL_LSB+:3];
    wire bt_inter = mode_r[BT_BIT];
    wire [2:0] lat_code = mode_r[LAT_LSB+:3];
    wire single_wr = mode_r[WBM_BIT];
    wire lat3 = (lat_code == LAT_THREE);
    wire is_page = (bl_code == BL_PAGE);
    // number of low address bits that wrap; reserved codes act as length one
    wire [2:0] wbits = (bl_code == BL_TWO) ? 3'h1 : (bl_code == BL_FOUR) ? 3'h2 :
        (bl_code == BL_EIGHT) ? 3'h3 : 3'h0;
    wire [COL_W-1:0] start_col = addr_in[COL_W-1:0];
    wire [COL_W-1:0] one_c = {{(COL_W-1){1'b0}}, 1'b1};
    wire [COL_W-1:0] burst_len = is_page ? {COL_W{1'b1}} : (one_c << wbits);
    // writes collapse to one location when the single-write bit is set
    wire [COL_W-1:0] wr_len = single_wr ? one_c : burst_len;
    wire [2:0] wmask = 3'((4'h1 << wrap_bits_r) - 4'h1);
    wire [2:0] nidx = idx_r[2:0] + 3'h1;
    // sequential: start+k wraps in block; interleaved: start xor k
    wire [2:0] off_seq = (start_r + nidx) & wmask;
    wire [2:0] off_int = (start_r ^ nidx) & wmask;
    wire [2:0] off_nxt = interleave_r ? off_int : off_seq;
    wire [COL_W-1:0] block_col = (base_r & ~{{(COL_W-3){1'b0}}, wmask}) |
        {{(COL_W-3){1'b0}}, off_nxt};
    wire [COL_W-1:0] col_nxt = page_r ? col_r + one_c : block_col;
    wire bursting = (state_r != ST_IDLE);
    wire more = (left_r != '0) || page_r;
    wire new_cmd = rd_cmd || wr_cmd;

    always_comb begin
        state_nxt = state_r;
        if (new_cmd) begin
            state_nxt = rd_cmd ? ST_READ : ST_WRITE;
        end else if (stop_cmd || !more) begin
            state_nxt = ST_IDLE;
        end
    end

    // registers change only on reset or a load command; nothing else writes them
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            mode_r <= MODE_RST;
            ext_r <= EXT_RST;
        end else begin
            if (load_main) mode_r <= addr_in;
            if (load_ext) ext_r <= addr_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            state_r <= ST_IDLE;
            base_r <= '0;
            col_r <= '0;
            start_r <= '0;
            idx_r <= '0;
            left_r <= '0;
            interleave_r <= 1'b0;
            wrap_bits_r <= '0;
            page_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (new_cmd) begin
                base_r <= start_col;
                col_r <= start_col;
                start_r <= start_col[2:0] & 3'((4'h1 << wbits) - 4'h1);
                idx_r <= '0;
                left_r <= (rd_cmd ? burst_len : wr_len) - one_c;
                // interleave is never applied to full page
                interleave_r <= bt_inter && !is_page;
                wrap_bits_r <= wbits;
                page_r <= is_page && !(wr_cmd && single_wr);
            end else if (bursting && more) begin
                col_r <= col_nxt;
                idx_r <= idx_r + one_c;
                if (!page_r) left_r <= left_r - one_c;
            end
        end
    end

    // read data: two-stage pipeline of every cycle's read access (command and burst), tap chosen by latency
    wire rd_access = (state_nxt == ST_READ) && (new_cmd || (bursting && more));
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            rd_pipe_r <= '0;
            dq_valid_out <= 1'b0;
            dq_drive_out <= 1'b0;
        end else begin
            rd_pipe_r <= {rd_pipe_r[0], rd_access && !stop_cmd};
            dq_valid_out <= lat3 ? rd_pipe_r[1] : rd_pipe_r[0];
            dq_drive_out <= (lat3 ? rd_pipe_r[0] : (rd_access && !stop_cmd)) ||
                (lat3 ? rd_pipe_r[1] : rd_pipe_r[0]);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            column_out <= '0;
            access_read_out <= 1'b0;
            access_write_out <= 1'b0;
            operating_mode_config_out <= MODE_RST;
            extended_mode_config_out <= EXT_RST;
            normal_mode_out <= 1'b1;
        end else begin
            column_out <= new_cmd ? start_col : col_nxt;
            access_read_out <= (state_nxt == ST_READ) && !stop_cmd &&
                (new_cmd || (bursting && more));
            access_write_out <= (state_nxt == ST_WRITE) && !stop_cmd &&
                (new_cmd || (bursting && more));
            operating_mode_config_out <= load_main ? addr_in : mode_r;
            extended_mode_config_out <= load_ext ? addr_in : ext_r;
            normal_mode_out <= (load_main ? addr_in[OPM_LSB+:2] :
                mode_r[OPM_LSB+:2]) == OPM_NORMAL;
        end
    end

    a_mode_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        !load_main |=> mode_r == $past(mode_r))
        else $error("mode register changed without load");
    a_ext_load: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        load_ext |=> ext_r == $past(addr_in))
        else $error("extended register not loaded");
    // a write issued right behind the first one legally restarts the access
    a_wr_single: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        wr_cmd && single_wr |=> access_write_out ##1
        (!access_write_out || $past(wr_cmd)))
        else $error("single write ran longer than one location");
    a_stop_ends: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        stop_cmd && !new_cmd |=> state_r == ST_IDLE)
        else $error("burst did not stop");
    a_lat_two: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        rd_cmd && lat_code == LAT_TWO && !load_main |-> ##2 dq_valid_out)
        else $error("read data late at latency two");
    a_drive_early: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        rd_cmd && lat3 && !load_main |-> ##2 dq_drive_out ##1 dq_valid_out)
        else $error("drive not one cycle before data");
    a_int_order: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        bursting && more && !new_cmd && interleave_r && !stop_cmd
        |=> column_out[2:0] == ((start_r ^ $past(nidx)) & wmask))
        else $error("interleaved offset wrong");
    a_block_wrap: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        bursting && !page_r && !new_cmd |=>
        (column_out >> wrap_bits_r) == (base_r >> wrap_bits_r))
        else $error("burst left its block");
    a_page_inc: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        bursting && page_r && !new_cmd && !stop_cmd
        |=> column_out == $past(col_r) + one_c)
        else $error("full page column did not increment");
    c_read_burst: cover property (@(posedge clk_sys_in) rd_cmd ##3 dq_valid_out);
    c_page_stop: cover property (@(posedge clk_sys_in) page_r ##1 stop_cmd);
    c_ext_load: cover property (@(posedge clk_sys_in) load_ext);
    c_interleave: cover property (@(posedge clk_sys_in) interleave_r && wrap_bits_r == 3'h3);
endmodule : sdram_mode_burst

// file: verif/mem_ctrl_model.sv
// controller model: drives the command and address pins of the mode block
// assumes every task is entered 1 ns after a rising clock edge
`timescale 1ns/1ps
module mem_ctrl_model
    import sdram_mode_pkg::*;
(
    // clock
    input wire logic clk_in,
    // command and address pins
    output logic [3:0] cmd_out,
    output logic [1:0] bank_out,
    output logic [MODE_W-1:0] addr_out
);
    initial begin
        cmd_out = 4'hf;
        bank_out = 2'h0;
        addr_out = 13'h0_000;
    end
    task issue(input logic [3:0] cmd, input logic [1:0] ba, input logic [MODE_W-1:0] a);
        cmd_out = cmd;
        bank_out = ba;
        addr_out = a;
        @(posedge clk_in);
        #1;
        cmd_out = 4'hf;
        // released bank and address pins show the inverse so a stale value cannot pass
        bank_out = ~ba;
        addr_out = ~a;
    endtask : issue
    // banks are idle whenever the bench loads; the gap covers the load delay
    task load(input logic [1:0] ba, input logic [MODE_W-1:0] a);
        issue(CMD_LOAD_MODE, ba, a);
        repeat (2) @(posedge clk_in);
        #1;
    endtask : load
endmodule : mem_ctrl_model

// file: verif/sdram_mode_and_burst_sequencing_test.sv
// self-checking bench for the mode register and burst sequencing block
// assumes the controller model drives all command pins 1 ns after each edge
`timescale 1ns/1ps
module sdram_mode_and_burst_sequencing_test;
    import sdram_mode_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [MODE_W-1:0] a, mcfg, ecfg, w;
    logic [8:0] col;
    logic rd, wr, drv, vld, nrm;
    int errors = 0;
    int n_compared = 0;
    logic [2:0] blc [4] = '{BL_FOUR, BL_EIGHT, BL_TWO, BL_ONE};
    int bn [4] = '{4, 8, 2, 1};
    int lm [4] = '{2, 3, 2, 3};
    int st [4] = '{5, 13, 1, 7};
    logic il [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    always #50 clk_sys_in = ~clk_sys_in;
    mem_ctrl_model i_ctrl (.clk_in(clk_sys_in), .cmd_out(cmd), .bank_out(ba), .addr_out(a));
    sdram_mode_burst #(.COL_W(9)) i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .cs_n_in(cmd[3]), .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]),
        .bank_addr_in(ba), .addr_in(a), .column_out(col), .access_read_out(rd),
        .access_write_out(wr), .dq_drive_out(drv), .dq_valid_out(vld),
        .operating_mode_config_out(mcfg), .extended_mode_config_out(ecfg),
        .normal_mode_out(nrm));
    function automatic logic [MODE_W-1:0] mode_word(input logic [2:0] bl, input logic bt,
            input logic [2:0] lat, input logic wbm);
        return {3'h0, wbm, 2'h0, lat, bt, bl};
    endfunction : mode_word
    task check(input logic [MODE_W-1:0] got, input logic [MODE_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task summarize;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // one sample per cycle, k counts edges after the read was taken
    task run_read(input int start, input int bl, input int m, input logic lv);
        int off;
        i_ctrl.issue(CMD_READ, 2'h0, MODE_W'(start));
        for (int k = 0; k <= m + bl; k++) begin
            off = lv ? (start % bl) ^ k : (start % bl + k) % bl;
            if (k < bl) check(MODE_W'(col), MODE_W'(start - start % bl + off));
            check(MODE_W'(rd), MODE_W'(k < bl));
            // flags are registered: one due at edge n+j already stands after edge n+j-1
            check(MODE_W'(drv), MODE_W'(k >= m - 2 && k < m + bl - 1));
            check(MODE_W'(vld), MODE_W'(k >= m - 1 && k < m + bl - 1));
            @(posedge clk_sys_in);
            #1;
        end
    endtask : run_read
    initial begin
        #100_000;
        errors++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        #1 rstn_in = 1'b1;
        check(mcfg, MODE_RST);
        check(ecfg, EXT_RST);
        check(MODE_W'(nrm), MODE_W'(1'b1));
        for (int i = 0; i < 4; i++) begin
            w = mode_word(blc[i], il[i], lm[i] == 2 ? LAT_TWO : LAT_THREE, 1'b0);
            i_ctrl.load(2'h0, w);
            check(mcfg, w);
            run_read(st[i], bn[i], lm[i], il[i]);
        end
        i_ctrl.load(BA_EXT, 13'h0_005);
        check(ecfg, 13'h0_005);
        check(mcfg, w);
        i_ctrl.load(2'h1, 13'h0_1ff);
        check(mcfg, w);
        w = mode_word(BL_FOUR, 1'b0, LAT_TWO, 1'b1);
        i_ctrl.load(2'h0, w);
        i_ctrl.issue(CMD_WRITE, 2'h0, 13'h0_004);
        check(MODE_W'(wr), MODE_W'(1'b1));
        @(posedge clk_sys_in);
        #1 check(MODE_W'(wr), MODE_W'(1'b0));
        run_read(6, 4, 2, 1'b0);
        i_ctrl.load(2'h0, w | 13'h0_080);
        check(MODE_W'(nrm), MODE_W'(1'b0));
        // burst write of eight, interleaved from offset 3 of block 8
        i_ctrl.load(2'h0, mode_word(BL_EIGHT, 1'b1, LAT_TWO, 1'b0));
        check(MODE_W'(nrm), MODE_W'(1'b1));
        i_ctrl.issue(CMD_WRITE, 2'h0, 13'h0_00b);
        for (int k = 0; k <= 8; k++) begin
            if (k < 8) check(MODE_W'(col), MODE_W'(8 + (3 ^ k)));
            check(MODE_W'(wr), MODE_W'(k < 8));
            check(MODE_W'(drv), MODE_W'(1'b0));
            @(posedge clk_sys_in);
            #1;
        end
        // interleave requested with full page must still run sequential
        i_ctrl.load(2'h0, mode_word(BL_PAGE, 1'b1, LAT_TWO, 1'b0));
        i_ctrl.issue(CMD_READ, 2'h0, 13'h0_1fe);
        for (int k = 0; k < 4; k++) begin
            check(MODE_W'(col), MODE_W'((9'h1fe + k) % 512));
            @(posedge clk_sys_in);
            #1;
        end
        i_ctrl.issue(CMD_BURST_STOP, 2'h0, 13'h0_000);
        check(MODE_W'(rd), MODE_W'(1'b0));
        check(MODE_W'(vld), MODE_W'(1'b1));
        @(posedge clk_sys_in);
        #1 check(MODE_W'(vld), MODE_W'(1'b0));
        summarize();
    end
endmodule : sdram_mode_and_burst_sequencing_test
